// ===== nic_pkg.sv
// Constants, encodings and helpers shared by the nested interrupt controller
// ============================================================================
package nic_pkg;

   // ============================================================
   // Level bit pairs {high, low}
   localparam logic [1:0] NIC_LVL0     = 2'h2;       // Main program
   localparam logic [1:0] NIC_LVL1     = 2'h1;
   localparam logic [1:0] NIC_LVL2     = 2'h0;
   localparam logic [1:0] NIC_LVL3     = 2'h3;       // Interrupts disabled

   // ============================================================
   // Condition code positions and idle value
   localparam int         NIC_CC_HI_POS = 5;
   localparam int         NIC_CC_LO_POS = 3;
   localparam logic [7:0] NIC_CC_FIXED  = 8'hC0;     // Bits 7:6 read as one

   // ============================================================
   // Vector map
   localparam logic [15:0] NIC_VEC_RESET  = 16'hFFFE;
   localparam logic [15:0] NIC_VEC_TRAP   = 16'hFFFC;
   localparam logic [15:0] NIC_VEC_TOP    = 16'hFFFA; // Pin vector, index 0
   localparam logic [15:0] NIC_VEC_BOTTOM = 16'hFFE0;
   localparam int          NIC_MAX_VEC    = 16;       // Incl. reset and trap
   localparam int          NIC_FIELDS     = 16;       // Level fields in total
   localparam int          NIC_RO_FIELD   = 14;       // Fields from here are fixed
   localparam logic [7:0]  NIC_PRIO_RST   = 8'hFF;

   // ============================================================
   // Level pair to rank 0..3
   function automatic logic [1:0] nic_rank(input logic [1:0] enc);
      case (enc)
         NIC_LVL0: nic_rank = 2'h0;
         NIC_LVL1: nic_rank = 2'h1;
         NIC_LVL2: nic_rank = 2'h2;
         default:  nic_rank = 2'h3;
      endcase
   endfunction

endpackage

// ===== nic_core.sv
// Nested interrupt controller: request latching, arbitration and entry sequence
`timescale 1ns/100ps
module nic_core import nic_pkg::*; #(
   parameter int NUM_VEC  = 14,   // Top pin vector plus maskable vectors
   parameter int EXT_BASE = 2,    // First vector fed by external groups
   parameter int NUM_EXT  = 4,    // External groups
   parameter int GRP_W    = 4     // Pins per external group
) (
   input  wire logic                       clk_sys,
   input  wire logic                       rst_n,
   input  wire logic                       instrBoundary,  // Instruction ends
   input  wire logic                       trapExec,       // Trap executed
   input  wire logic                       haltMode,       // Core halted
   input  wire logic                       ccRestore,      // Pop of level bits
   input  wire logic [7:0]                 ccRestoreVal,
   input  wire logic                       top_level_pin_irq,
   input  wire logic                       tliRiseSel,     // 1 rising, 0 falling
   input  wire logic [NUM_EXT*GRP_W-1:0]   extPins,
   input  wire logic [NUM_EXT*GRP_W-1:0]   extPinSel,
   input  wire logic [NUM_EXT-1:0]         extEdgeSel,     // 1 edge, 0 level
   input  wire logic [NUM_VEC-1:0]         perFlag,
   input  wire logic [NUM_VEC-1:0]         perEnable,
   input  wire logic                       prioWrEn,
   input  wire logic [1:0]                 prioWrIdx,
   input  wire logic [7:0]                 prioWrData,
   input  wire logic [1:0]                 prioRdIdx,
   output logic      [7:0]                 prioRdData,
   output logic                            stackReq,
   input  wire logic                       stackDone,
   output logic                            vecLoad,
   output logic      [15:0]                vecAddr,
   output logic      [7:0]                 condition_code_reg,
   output logic                            wakeReq
);

   // ============================================================
   // Elaboration checks
   if (NUM_VEC + 2 > NIC_MAX_VEC || NUM_VEC < 2) begin : g_bad_vec
      $error("nic_core: NUM_VEC out of range");
   end
   if (EXT_BASE < 1 || EXT_BASE + NUM_EXT > NUM_VEC || GRP_W < 1) begin : g_bad_ext
      $error("nic_core: external group mapping out of range");
   end

   // ============================================================
   // Declarations
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,                    // Waiting for a boundary
      ST_STACK = 4'h2,                    // Core pushes context
      ST_LEVEL = 4'h4,                    // Level bits loaded
      ST_FETCH = 4'h8                     // Vector handed to core
   } nic_state_t;

   nic_state_t          stateQ;          // Entry sequencer
   logic                level_bit_high;  // Current level, high bit
   logic                level_bit_low;   // Current level, low bit
   logic [1:0]          prioField_q [NIC_FIELDS];   // Per-vector levels
   logic [NUM_VEC-1:0]  req;             // Registered maskable requests
   logic                tliPrev_q;       // Pin history for edge detect
   logic                tliPend_q;       // Latched pin request
   logic                trapPend_q;      // Latched trap request
   logic                winValid;        // Some request may be taken
   logic                winNmi;          // Winner is non-maskable
   logic                winTrap;         // Winner is the trap
   logic [3:0]          winIdx;          // Winning vector index
   logic [1:0]          winRank;         // Winner rank
   logic [1:0]          winLevel;        // Level pair for the winner
   logic [1:0]          curRank;         // Rank of current level
   logic                svcStart;        // Entry begins this cycle
   logic [1:0]          svcLevel_q;      // Level captured at entry
   logic [3:0]          svcIdx_q;        // Vector captured at entry
   logic                svcNmi_q;        // Entry is non-maskable
   logic [15:0]         vecAddr_q;       // Vector for fetch
   logic                extWake;         // Some external group active

   assign curRank = nic_rank({level_bit_high, level_bit_low});
   assign svcStart = (stateQ == ST_IDLE) && instrBoundary && winValid;

   // ============================================================
   // Maskable request sources, one slice per vector
   logic [NUM_EXT-1:0] grpAct;           // Group OR, for halt wake
   assign req[0] = 1'b0;                 // Index 0 is the pin, handled apart
   for (genvar v = 1; v < NUM_VEC; v++) begin : g_vec
      if (v >= EXT_BASE && v < EXT_BASE + NUM_EXT) begin : g_ext
         localparam int G = v - EXT_BASE;
         logic grpOr;                     // Selected pins combined
         logic grpPrev_q;                 // Registered group level
         logic extLatch_q;                // Edge request latch
         assign grpOr = |(extPins[G*GRP_W +: GRP_W] & extPinSel[G*GRP_W +: GRP_W]);
         assign grpAct[G] = grpOr;
         // Level history and edge latch; a new edge beats the entry clear
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               grpPrev_q  <= 1'b0;
               extLatch_q <= 1'b0;
            end else begin
               grpPrev_q <= grpOr;
               if (extEdgeSel[G] && grpOr && !grpPrev_q) begin
                  extLatch_q <= 1'b1;
               end else if (svcStart && !winNmi && winIdx == 4'(v)) begin
                  extLatch_q <= 1'b0;
               end
            end
         end
         // Registered so a fresh request waits one clock cycle
         assign req[v] = extEdgeSel[G] ? extLatch_q : grpPrev_q;
      end else begin : g_per
         logic perReq_q;                  // Peripheral request, registered
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               perReq_q <= 1'b0;
            end else begin
               perReq_q <= perFlag[v] & perEnable[v];
            end
         end
         assign req[v] = perReq_q;        // Flag holds it pending
      end
   end

   // ============================================================
   // Level fields; writes of level 0 are dropped per field
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int f = 0; f < NIC_FIELDS; f++) begin
            prioField_q[f] <= NIC_LVL3;
         end
      end else if (prioWrEn) begin
         for (int f = 0; f < 4; f++) begin
            if (prioWrData[2*f +: 2] != NIC_LVL0 &&
                (4 * int'(prioWrIdx) + f) < NIC_RO_FIELD) begin
               prioField_q[4*prioWrIdx + f] <= prioWrData[2*f +: 2];
            end
         end
      end
   end

   // Registered read of one field group
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prioRdData <= NIC_PRIO_RST;
      end else begin
         for (int f = 0; f < 4; f++) begin
            prioRdData[2*f +: 2] <= prioField_q[4*prioRdIdx + f];
         end
      end
   end

   // ============================================================
   // Non-maskable latches; a new event beats the entry clear
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tliPrev_q <= 1'b0;
         tliPend_q <= 1'b0;
      end else begin
         tliPrev_q <= top_level_pin_irq;
         if (tliRiseSel ? (top_level_pin_irq && !tliPrev_q)
                        : (!top_level_pin_irq && tliPrev_q)) begin
            tliPend_q <= 1'b1;
         end else if (svcStart && winNmi && !winTrap) begin
            tliPend_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         trapPend_q <= 1'b0;
      end else if (trapExec) begin
         trapPend_q <= 1'b1;
      end else if (svcStart && winTrap) begin
         trapPend_q <= 1'b0;
      end
   end

   // ============================================================
   // Arbitration: non-maskable first, then rank, then lowest index
   always_comb begin
      winValid = 1'b0;
      winNmi   = 1'b0;
      winTrap  = 1'b0;
      winIdx   = 4'h0;
      winRank  = 2'h0;
      // Descending scan with >= leaves the lowest index on ties
      for (int v = NUM_VEC - 1; v >= 1; v--) begin
         if (req[v] && nic_rank(prioField_q[v]) > curRank &&
             (!winValid || nic_rank(prioField_q[v]) >= winRank)) begin
            winValid = 1'b1;
            winIdx   = 4'(v);
            winRank  = nic_rank(prioField_q[v]);
         end
      end
      if (tliPend_q) begin
         winValid = 1'b1;
         winNmi   = 1'b1;
         winIdx   = 4'h0;
      end
      if (trapPend_q) begin
         winValid = 1'b1;
         winNmi   = 1'b1;
         winTrap  = 1'b1;
         winIdx   = 4'h0;
      end
   end

   assign winLevel = winNmi ? NIC_LVL3 : prioField_q[winIdx];

   // ============================================================
   // Entry sequencer; reset enters straight at fetch, no stacking
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stateQ <= ST_FETCH;
      end else begin
         case (stateQ)
            ST_IDLE:  if (svcStart) begin
                         stateQ <= ST_STACK;
                      end
            ST_STACK: if (stackDone) begin
                         stateQ <= ST_LEVEL;
                      end
            ST_LEVEL: stateQ <= ST_FETCH;
            ST_FETCH: stateQ <= ST_IDLE;
            default:  stateQ <= ST_IDLE;
         endcase
      end
   end

   // Capture of winner at entry, held for the whole sequence
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         svcLevel_q <= NIC_LVL3;
         svcIdx_q   <= 4'h0;
         svcNmi_q   <= 1'b1;
      end else if (svcStart) begin
         svcLevel_q <= winLevel;
         svcIdx_q   <= winIdx;
         svcNmi_q   <= winNmi;
      end
   end

   // Vector address: reset, trap, or pin minus two per index
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         vecAddr_q <= NIC_VEC_RESET;
      end else if (svcStart) begin
         vecAddr_q <= winTrap ? NIC_VEC_TRAP
                              : NIC_VEC_TOP - {11'h000, winIdx, 1'b0};
      end
   end

   // ============================================================
   // Current level bits; hardware load wins over a pop
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         level_bit_high <= NIC_LVL3[1];
         level_bit_low  <= NIC_LVL3[0];
      end else if (stateQ == ST_LEVEL) begin
         level_bit_high <= svcLevel_q[1];
         level_bit_low  <= svcLevel_q[0];
      end else if (ccRestore) begin
         level_bit_high <= ccRestoreVal[NIC_CC_HI_POS];
         level_bit_low  <= ccRestoreVal[NIC_CC_LO_POS];
      end
   end

   // ============================================================
   // Outputs
   always_comb begin
      condition_code_reg = NIC_CC_FIXED;
      condition_code_reg[NIC_CC_HI_POS] = level_bit_high;
      condition_code_reg[NIC_CC_LO_POS] = level_bit_low;
   end

   assign stackReq = (stateQ == ST_STACK);
   assign vecLoad  = (stateQ == ST_FETCH);
   assign vecAddr  = vecAddr_q;
   assign extWake  = |grpAct;
   // Wake only needs a level; the sequencer resolves the winner later
   assign wakeReq  = haltMode && (tliPend_q || trapPend_q || extWake);

   // ============================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_level_then_fetch;
      (stateQ == ST_LEVEL) ##1 vecLoad;
   endsequence

   sequence s_entry;
      svcStart ##1 stackReq;
   endsequence

   chk_stack_then_vec: assert property (stackReq && stackDone |=> s_level_then_fetch)
      else $error("fetch did not follow stacking");
   chk_start_stacks: assert property (svcStart |-> s_entry)
      else $error("entry did not begin with stacking");
   chk_start_boundary: assert property ($rose(stackReq) |-> $past(instrBoundary))
      else $error("entry not at instruction boundary");
   chk_level_loaded: assert property ((stateQ == ST_LEVEL) |=>
         {level_bit_high, level_bit_low} == $past(svcLevel_q))
      else $error("level bits not loaded at entry");
   chk_nmi_level: assert property (vecLoad && svcNmi_q |->
         {level_bit_high, level_bit_low} == NIC_LVL3)
      else $error("non-maskable entry not at level 3");
   chk_mask_rank: assert property (svcStart && !winNmi |->
         nic_rank(prioField_q[winIdx]) > curRank)
      else $error("maskable taken without higher level");
   chk_zero_write: assert property (prioWrEn && prioWrIdx == 2'h0 &&
         prioWrData[1:0] == NIC_LVL0 |=> prioField_q[0] == $past(prioField_q[0]))
      else $error("level 0 write altered a field");
   chk_trap_clear: assert property (svcStart && winTrap && !trapExec |=> !trapPend_q)
      else $error("trap not cleared on entry");
   chk_halt_wake: assert property (haltMode && tliPend_q |-> wakeReq)
      else $error("pin request did not wake");
   chk_vec_range: assert property (vecLoad |-> vecAddr >= NIC_VEC_BOTTOM)
      else $error("vector below table");

   // Pulses and holds of the entry handshake
   chk_fetch_once: assert property (vecLoad |=> !vecLoad)
      else $error("vector fetch lasted more than one cycle");
   chk_stack_hold: assert property (stackReq && !stackDone |=> stackReq)
      else $error("stacking request dropped early");

   // A pop outside the level-load cycle lands in the level bits
   chk_pop_level: assert property (ccRestore && stateQ != ST_LEVEL |=>
         level_bit_high == $past(ccRestoreVal[NIC_CC_HI_POS]) &&
         level_bit_low == $past(ccRestoreVal[NIC_CC_LO_POS]))
      else $error("popped level bits not restored");

   // Non-maskable entries aim at their fixed vectors
   chk_nmi_vector: assert property (svcStart && winNmi |=>
         vecAddr == ($past(winTrap) ? NIC_VEC_TRAP : NIC_VEC_TOP))
      else $error("non-maskable entry took a wrong vector");

   // Pin edges in either sense, and the fields that never change
   chk_pin_rise: assert property (tliRiseSel && $rose(top_level_pin_irq) |=> tliPend_q)
      else $error("rising pin edge not latched");
   chk_pin_fall: assert property (!tliRiseSel && $fell(top_level_pin_irq) |=> tliPend_q)
      else $error("falling pin edge not latched");
   chk_fixed_fields: assert property (prioField_q[NIC_RO_FIELD] == NIC_LVL3 &&
         prioField_q[NIC_FIELDS - 1] == NIC_LVL3)
      else $error("fixed level field changed");

endmodule // nic_core

// ===== nic_core_model.sv
// Core sequencer model: instruction boundaries and context stacking answers
`timescale 1ns/100ps
module nic_core_model (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic stackReq,
   output logic      instrBoundary,
   output logic      stackDone
);
   // ============================================================
   // Model state
   logic [1:0] phase_q;    // Position inside a three-cycle instruction
   logic [2:0] waitCnt_q;  // Cycles spent stacking so far
   logic       slow_q;     // Next stacking answers slowly

   // Driven on the falling edge so the design samples settled levels
   always_ff @(negedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         phase_q       <= 2'h0;
         waitCnt_q     <= 3'h0;
         slow_q        <= 1'b0;
         instrBoundary <= 1'b0;
         stackDone     <= 1'b0;
      end else begin
         // Boundary only every third cycle, so entry must wait for it
         phase_q       <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
         instrBoundary <= (phase_q == 2'h2);
         stackDone     <= 1'b0;
         // Pushing PC, X, A and CC takes two or five cycles in turn
         if (stackReq && !stackDone) begin
            if (waitCnt_q == (slow_q ? 3'h4 : 3'h1)) begin
               stackDone <= 1'b1;
               waitCnt_q <= 3'h0;
               slow_q    <= !slow_q;
            end else begin
               waitCnt_q <= waitCnt_q + 3'h1;
            end
         end
      end
   end
endmodule // nic_core_model

// ===== test_nested_interrupt_controller.sv
// Self-checking bench for the nested interrupt controller core
`timescale 1ns/100ps
module test_nested_interrupt_controller import nic_pkg::*;;
   // ============================================================
   // Table row: requests, priorities, level, expected entry
   typedef struct packed {
      logic [13:0] flag;    // Peripheral flags
      logic [13:0] en;      // Peripheral enables
      logic [15:0] pins;    // External pin levels
      logic [31:0] prio;    // Priority registers 3..0
      logic [1:0]  lvl;     // Level before requests
      logic [15:0] vec;     // Expected vector, zero for none
      logic [1:0]  expLvl;  // Level after entry
   } nic_row_t;
   localparam nic_row_t ROWS [9] = '{
      {14'h0002, 14'h0002, 16'h0000, 32'hFFFFFFFF, NIC_LVL0, 16'hFFF8, NIC_LVL3},
      {14'h0042, 14'h0042, 16'h0000, 32'hFFFFFFFF, NIC_LVL0, 16'hFFF8, NIC_LVL3},
      {14'h0042, 14'h0042, 16'h0000, 32'hFFFFCFF7, NIC_LVL0, 16'hFFEE, NIC_LVL2},
      {14'h0002, 14'h0002, 16'h0000, 32'hFFFFFFF7, NIC_LVL1, 16'h0000, NIC_LVL1},
      {14'h0002, 14'h0002, 16'h0000, 32'hFFFFFFF3, NIC_LVL1, 16'hFFF8, NIC_LVL2},
      {14'h0040, 14'h0000, 16'h0000, 32'hFFFFFFFF, NIC_LVL0, 16'h0000, NIC_LVL0},
      {14'h0000, 14'h0000, 16'h0002, 32'hFFFFFFFF, NIC_LVL0, 16'hFFF6, NIC_LVL3},
      {14'h2000, 14'h2000, 16'h0100, 32'hFFFFFFFF, NIC_LVL0, 16'hFFF2, NIC_LVL3},
      {14'h2000, 14'h2000, 16'h0000, 32'hFFFFFFFF, NIC_LVL0, 16'hFFE0, NIC_LVL3}};

   // ============================================================
   // Stimulus and observed signals
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        trapExec = 1'b0;           // Trap pulse
   logic        haltMode = 1'b0;           // Core halted
   logic        ccRestore = 1'b0;          // Level pop pulse
   logic [7:0]  ccRestoreVal = 8'h00;
   logic        top_level_pin_irq = 1'b0;
   logic        tliRiseSel = 1'b1;         // Rising edge only
   logic [15:0] extPins = 16'h0000;
   logic [15:0] extPinSel = 16'hFFFF;      // Every pin joins its group
   logic [3:0]  extEdgeSel = 4'h0;         // Level mode unless a test edges
   logic [13:0] perFlag = 14'h0000;
   logic [13:0] perEnable = 14'h0000;
   logic        prioWrEn = 1'b0;
   logic [1:0]  prioWrIdx = 2'h0;
   logic [7:0]  prioWrData = 8'h00;
   logic [1:0]  prioRdIdx = 2'h0;
   logic [7:0]  prioRdData;
   logic        stackReq;
   logic        stackDone;
   logic        instrBoundary;
   logic        vecLoad;
   logic [15:0] vecAddr;
   logic [7:0]  condition_code_reg;
   logic        wakeReq;
   int          mismatches = 0;
   int          checks = 0;

   // Free-running 50 MHz clock
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end

   nic_core u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .instrBoundary(instrBoundary),
      .trapExec(trapExec), .haltMode(haltMode), .ccRestore(ccRestore),
      .ccRestoreVal(ccRestoreVal), .top_level_pin_irq(top_level_pin_irq),
      .tliRiseSel(tliRiseSel), .extPins(extPins), .extPinSel(extPinSel),
      .extEdgeSel(extEdgeSel), .perFlag(perFlag), .perEnable(perEnable),
      .prioWrEn(prioWrEn), .prioWrIdx(prioWrIdx), .prioWrData(prioWrData),
      .prioRdIdx(prioRdIdx), .prioRdData(prioRdData), .stackReq(stackReq),
      .stackDone(stackDone), .vecLoad(vecLoad), .vecAddr(vecAddr),
      .condition_code_reg(condition_code_reg), .wakeReq(wakeReq));
   nic_core_model u_core (.clk_sys(clk_sys), .rst_n(rst_n), .stackReq(stackReq),
      .instrBoundary(instrBoundary), .stackDone(stackDone));

   // ============================================================
   // Helpers
   // Condition code image for a level pair
   function automatic logic [7:0] ccOf(input logic [1:0] l);
      ccOf = NIC_CC_FIXED | {2'b00, l[1], 1'b0, l[0], 3'b000};
   endfunction

   task automatic compare(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      if (mismatches == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Stands in for a pop of the condition code
   task automatic setLevel(input logic [1:0] l);
      @(negedge clk_sys);
      ccRestoreVal = ccOf(l);
      ccRestore = 1'b1;
      @(negedge clk_sys);
      ccRestore = 1'b0;
   endtask

   task automatic prioWrite(input logic [1:0] idx, input logic [7:0] data);
      @(negedge clk_sys);
      prioWrIdx = idx;
      prioWrData = data;
      prioWrEn = 1'b1;
      @(negedge clk_sys);
      prioWrEn = 1'b0;
   endtask

   // Read data is registered, so look one cycle after the index
   task automatic readPrio(input logic [1:0] idx, input logic [7:0] exp);
      @(negedge clk_sys);
      prioRdIdx = idx;
      @(negedge clk_sys);
      compare({8'h00, prioRdData}, {8'h00, exp});
   endtask

   // Bounded wait for the one-cycle fetch pulse, then check vector and level
   task automatic waitEntry(input logic [15:0] vec, input logic [1:0] l);
      int n;
      int stk;                             // Cycles seen with stacking requested
      n = 0;
      stk = 0;
      do begin
         @(negedge clk_sys);
         n++;
         if (stackReq === 1'b1) stk++;
      end while (vecLoad !== 1'b1 && n < 40);
      if (vecLoad !== 1'b1) begin
         mismatches++;
         $display("unexpected at %0t: no vector fetch", $time);
         summarize();
      end
      compare(vecAddr, vec);
      compare({8'h00, condition_code_reg}, {8'h00, ccOf(l)});
      compare({15'h0000, stk > 0}, 16'h0001);
   endtask

   // No fetch may appear over a long quiet stretch
   task automatic expectNone();
      int seen;
      seen = 0;
      repeat (30) begin
         @(negedge clk_sys);
         if (vecLoad === 1'b1) seen++;
      end
      compare(16'(seen), 16'h0000);
   endtask

   // ============================================================
   // Main sequence
   initial begin
      repeat (16) @(negedge clk_sys);
      compare({15'h0000, vecLoad}, 16'h0001);
      compare(vecAddr, NIC_VEC_RESET);
      compare({8'h00, condition_code_reg}, {8'h00, ccOf(NIC_LVL3)});
      rst_n = 1'b1;
      @(negedge clk_sys);
      compare({15'h0000, vecLoad}, 16'h0000);
      for (int i = 0; i < 4; i++) readPrio(2'(i), NIC_PRIO_RST);
      // Table of ordinary arbitration cases
      for (int i = 0; i < 9; i++) begin
         for (int j = 0; j < 4; j++) prioWrite(2'(j), ROWS[i].prio[8*j +: 8]);
         setLevel(ROWS[i].lvl);
         @(negedge clk_sys);
         perFlag = ROWS[i].flag;
         perEnable = ROWS[i].en;
         extPins = ROWS[i].pins;
         if (ROWS[i].vec !== 16'h0000) begin
            waitEntry(ROWS[i].vec, ROWS[i].expLvl);
         end else begin
            expectNone();
         end
         // Requests are dropped before the level is popped again
         perFlag = 14'h0000;
         perEnable = 14'h0000;
         extPins = 16'h0000;
         repeat (3) @(negedge clk_sys);
         setLevel(NIC_LVL0);
         @(negedge clk_sys);
         compare({8'h00, condition_code_reg}, {8'h00, ccOf(NIC_LVL0)});
      end
      // Trap and pin edge together at level 3: trap first, then pin
      setLevel(NIC_LVL3);
      @(negedge clk_sys);
      trapExec = 1'b1;
      top_level_pin_irq = 1'b1;
      @(negedge clk_sys);
      trapExec = 1'b0;
      waitEntry(NIC_VEC_TRAP, NIC_LVL3);
      waitEntry(NIC_VEC_TOP, NIC_LVL3);
      top_level_pin_irq = 1'b0;
      expectNone();
      // Falling sense: a rise is ignored, the fall is served
      tliRiseSel = 1'b0;
      top_level_pin_irq = 1'b1;
      expectNone();
      top_level_pin_irq = 1'b0;
      waitEntry(NIC_VEC_TOP, NIC_LVL3);
      tliRiseSel = 1'b1;
      // Edge-mode group is served once while its pin stays high
      setLevel(NIC_LVL0);
      extEdgeSel = 4'h2;
      extPins = 16'h0010;
      waitEntry(16'hFFF4, NIC_LVL3);
      setLevel(NIC_LVL0);
      expectNone();
      extPins = 16'h0000;
      // Group history must settle low first, or level mode sees a stale request
      @(negedge clk_sys);
      extEdgeSel = 4'h0;
      // Halt wake-up by external pin and by trap
      setLevel(NIC_LVL3);
      haltMode = 1'b1;
      extPins = 16'h0001;
      @(negedge clk_sys);
      compare({15'h0000, wakeReq}, 16'h0001);
      extPins = 16'h0000;
      @(negedge clk_sys);
      compare({15'h0000, wakeReq}, 16'h0000);
      trapExec = 1'b1;
      @(negedge clk_sys);
      trapExec = 1'b0;
      compare({15'h0000, wakeReq}, 16'h0001);
      waitEntry(NIC_VEC_TRAP, NIC_LVL3);
      haltMode = 1'b0;
      // Level 0 writes keep the old field; top fields stay fixed
      prioWrite(2'h0, 8'hCF);
      prioWrite(2'h0, 8'h64);
      readPrio(2'h0, 8'h44);
      prioWrite(2'h3, 8'h00);
      readPrio(2'h3, 8'hF0);
      // Reset in mid-run: reset vector again, no stacking, field group 3 back to ones
      rst_n = 1'b0;
      @(negedge clk_sys);
      compare(vecAddr, NIC_VEC_RESET);
      compare({15'h0000, stackReq}, 16'h0000);
      rst_n = 1'b1;
      readPrio(2'h3, NIC_PRIO_RST);
      summarize();
   end
endmodule // test_nested_interrupt_controller
